//--- hdl/oora_top.sv
// Purpose: out-of-range alarm threshold bank with AXI4-Lite access
// Assumes: samples arrive with a one-cycle strobe per channel
// Notes: reads of the status register clear the global alarm flag while no channel alarm is live
`timescale 1ns/1ps
module oora_top (
  input  wire logic                                     sys_clk,       // 100 MHz clock
  input  wire logic                                     srst,          // sync reset, high
  input  wire logic [oora_pkg::NUM_CH-1:0][oora_pkg::DATA_W-1:0] sample_data, // conversions
  input  wire logic [oora_pkg::NUM_CH-1:0]              sample_valid,  // conversion strobes
  input  wire logic [oora_pkg::ADDR_W-1:0]              s_axi_awaddr,  // write address
  input  wire logic [2:0]                               s_axi_awprot,  // unused
  input  wire logic                                     s_axi_awvalid, // write address valid
  output logic                                          s_axi_awready, // write address ready
  input  wire logic [31:0]                              s_axi_wdata,   // write data
  input  wire logic [3:0]                               s_axi_wstrb,   // byte enables
  input  wire logic                                     s_axi_wvalid,  // write data valid
  output logic                                          s_axi_wready,  // write data ready
  output logic [1:0]                                    s_axi_bresp,   // write response
  output logic                                          s_axi_bvalid,  // response valid
  input  wire logic                                     s_axi_bready,  // response ready
  input  wire logic [oora_pkg::ADDR_W-1:0]              s_axi_araddr,  // read address
  input  wire logic [2:0]                               s_axi_arprot,  // unused
  input  wire logic                                     s_axi_arvalid, // read address valid
  output logic                                          s_axi_arready, // read address ready
  output logic [31:0]                                   s_axi_rdata,   // read data
  output logic [1:0]                                    s_axi_rresp,   // read response
  output logic                                          s_axi_rvalid,  // read data valid
  input  wire logic                                     s_axi_rready,  // read data ready
  output logic [oora_pkg::NUM_CH-1:0]                   channel_alarm_flag, // alarms
  output logic                                          global_alarm_flag,  // sticky OR
  output logic                                          irq            // level interrupt
);
  import oora_pkg::*;

  logic [7:0]              thr_ff [THR_BYTES];
  logic [7:0]              hyst_ff [NUM_CH];
  logic                    aw_held_ff;
  logic [ADDR_W-1:0]       awaddr_ff;
  logic                    w_held_ff;
  logic [31:0]             wdata_ff;
  logic [3:0]              wstrb_ff;
  logic                    bvalid_ff;
  logic [1:0]              bresp_ff;
  logic                    rvalid_ff;
  logic [31:0]             rdata_ff;
  logic [1:0]              rresp_ff;
  logic                    global_ff;
  logic [NUM_CH-1:0]       alarm_prev_ff;
  logic [NUM_CH-1:0]       irq_stat_ff;
  logic [NUM_CH-1:0]       irq_mask_ff;
  logic [NUM_CH-1:0]       alarm;
  logic                    aw_have;
  logic                    w_have;
  logic                    do_write;
  logic [ADDR_W-1:0]       wr_addr;
  logic [31:0]             wr_data;
  logic [3:0]              wr_strb;
  logic [7:0]              wr_idx;
  logic                    wr_mapped;
  logic                    wr_byte;
  logic [7:0]              rd_idx;
  logic                    rd_take;
  logic                    status_rd;
  logic [31:0]             nxt_rdata;
  logic                    nxt_rmapped;
  logic [7:0]              thr_off;
  logic [7:0]              hyst_off;

  // reset value of one limit byte, selected by channel kind and byte position
  function automatic logic [7:0] thr_rst(input int i);
    logic [1:0] pos;
    logic       temp;
    pos  = 2'(i % 4);
    temp = (i / 4) == TEMP_CH;
    case (pos)
      POS_UP_LO: thr_rst = RST_UP_LO;
      POS_UP_HI: thr_rst = temp ? RST_TEMP_UP_HI : RST_IN_UP_HI;
      POS_LO_LO: thr_rst = RST_LO_LO;
      POS_LO_HI: thr_rst = temp ? RST_TEMP_LO_HI : RST_IN_LO_HI;
      default:   thr_rst = 8'h00;
    endcase
  endfunction : thr_rst

  // ---- write channel: address and data may arrive in either order
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign aw_have       = aw_held_ff || (s_axi_awvalid && s_axi_awready);
  assign w_have        = w_held_ff || (s_axi_wvalid && s_axi_wready);
  assign do_write      = aw_have && w_have && !bvalid_ff;
  assign wr_addr       = aw_held_ff ? awaddr_ff : s_axi_awaddr;
  assign wr_data       = w_held_ff ? wdata_ff : s_axi_wdata;
  assign wr_strb       = w_held_ff ? wstrb_ff : s_axi_wstrb;
  assign wr_idx        = wr_addr[9:2];
  assign thr_off       = wr_idx - IDX_THR_BASE;
  assign hyst_off      = wr_idx - IDX_HYST_BASE;
  // registers are 8 bits wide, so only byte lane 0 carries a write
  assign wr_byte       = do_write && wr_mapped && wr_strb[0];

  // decode whether a write index names a register
  always_comb begin
    wr_mapped = (wr_addr[ADDR_W-1:10] == '0) && (wr_addr[1:0] == 2'b00) &&
                ((thr_off < 8'(THR_BYTES)) || (hyst_off < 8'(NUM_CH)) ||
                 (wr_idx == IDX_STATUS) || (wr_idx == IDX_IRQ_STATUS) ||
                 (wr_idx == IDX_IRQ_MASK));
  end

  // hold whichever half of the write arrived first
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= '0;
      w_held_ff  <= 1'b0;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
    end
  end

  // write response one cycle after both halves are present
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // limit bytes keep all eight bits, spare bits included
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < THR_BYTES; i++) begin
        thr_ff[i] <= thr_rst(i);
      end
    end else if (wr_byte && (thr_off < 8'(THR_BYTES))) begin
      thr_ff[thr_off[4:0]] <= wr_data[7:0];
    end
  end

  // hysteresis registers, spare bits stored as well
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        hyst_ff[i] <= RST_HYST;
      end
    end else if (wr_byte && (hyst_off < 8'(NUM_CH))) begin
      hyst_ff[hyst_off[2:0]] <= wr_data[7:0];
    end
  end

  // ---- comparators: five unipolar precision inputs plus temperature
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      oora_chan_if chan ();
      assign chan.upper        = {thr_ff[4*g+1][3:0], thr_ff[4*g]};
      assign chan.lower        = {thr_ff[4*g+3][3:0], thr_ff[4*g+2]};
      assign chan.hyst         = (g == TEMP_CH) ?
                                 {2'b00, hyst_ff[g][TEMP_HYST_W-1:0]} :
                                 hyst_ff[g][HYST_W-1:0];
      assign chan.sample       = sample_data[g];
      assign chan.sample_valid = sample_valid[g];
      assign alarm[g]          = chan.alarm;
      oora_win_cmp #(
        .SIGNED_CMP (g == TEMP_CH),
        .HYST_SHIFT ((g == TEMP_CH) ? TEMP_HYST_SHIFT : 0)
      ) u_cmp (
        .sys_clk (sys_clk),
        .srst    (srst),
        .ch      (chan.cmp)
      );
    end
  endgenerate
  assign channel_alarm_flag = alarm;

  // ---- read channel: data registered, one read outstanding at a time
  assign s_axi_arready = !rvalid_ff;
  assign rd_take       = s_axi_arvalid && s_axi_arready;
  assign rd_idx        = s_axi_araddr[9:2];
  assign status_rd     = rd_take && nxt_rmapped && (rd_idx == IDX_STATUS);

  // read mux; unmapped reads return zero with an error response
  always_comb begin
    logic [7:0] roff;
    roff        = rd_idx - IDX_THR_BASE;
    nxt_rdata   = '0;
    nxt_rmapped = (s_axi_araddr[ADDR_W-1:10] == '0) && (s_axi_araddr[1:0] == 2'b00);
    if (roff < 8'(THR_BYTES)) begin
      nxt_rdata[7:0] = thr_ff[roff[4:0]];
    end else if ((8'(rd_idx - IDX_HYST_BASE)) < 8'(NUM_CH)) begin
      nxt_rdata[7:0] = hyst_ff[3'(rd_idx - IDX_HYST_BASE)];
    end else if (rd_idx == IDX_STATUS) begin
      nxt_rdata[NUM_CH-1:0]      = alarm;
      nxt_rdata[STAT_GLOBAL_BIT] = global_ff;
    end else if (rd_idx == IDX_IRQ_STATUS) begin
      nxt_rdata[NUM_CH-1:0] = irq_stat_ff;
    end else if (rd_idx == IDX_IRQ_MASK) begin
      nxt_rdata[NUM_CH-1:0] = irq_mask_ff;
    end else begin
      nxt_rmapped = 1'b0;
    end
    if (!nxt_rmapped) begin
      nxt_rdata = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rmapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // global flag: a live alarm beats the clearing read so none is lost
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      global_ff <= 1'b0;
    end else begin
      global_ff <= (|alarm) || (global_ff && !status_rd);
    end
  end
  assign global_alarm_flag = global_ff;

  // interrupt: rising alarm sets sticky bit, write one clears, set wins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      alarm_prev_ff <= '0;
      irq_stat_ff   <= '0;
      irq_mask_ff   <= '0;
    end else begin
      alarm_prev_ff <= alarm;
      irq_stat_ff   <= (alarm & ~alarm_prev_ff) |
                       (irq_stat_ff & ~((wr_byte && wr_idx == IDX_IRQ_STATUS) ?
                                        wr_data[NUM_CH-1:0] : '0));
      if (wr_byte && wr_idx == IDX_IRQ_MASK) begin
        irq_mask_ff <= wr_data[NUM_CH-1:0];
      end
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ---- checks
  property p_global_set;
    @(posedge sys_clk) disable iff (srst)
    |alarm |=> global_alarm_flag;
  endproperty
  a_global_set: assert property (p_global_set) else $error("global flag missed alarm");

  property p_global_hold;
    @(posedge sys_clk) disable iff (srst)
    global_alarm_flag && !status_rd |=> global_alarm_flag;
  endproperty
  a_global_hold: assert property (p_global_hold) else $error("global flag dropped early");

  property p_temp_reset;
    @(posedge sys_clk)
    srst |=> (g_ch[TEMP_CH].chan.upper == 12'h7ff) && (g_ch[TEMP_CH].chan.lower == 12'h800);
  endproperty
  a_temp_reset: assert property (p_temp_reset) else $error("temperature limit reset wrong");

  property p_input_reset;
    @(posedge sys_clk)
    srst |=> (g_ch[0].chan.upper == 12'hfff) && (g_ch[0].chan.lower == 12'h000) &&
             (hyst_ff[0] == 8'h08);
  endproperty
  a_input_reset: assert property (p_input_reset) else $error("input limit reset wrong");

  property p_limit_write;
    @(posedge sys_clk) disable iff (srst)
    wr_byte && wr_idx == IDX_TEMP_UP_HI |=> thr_ff[4*TEMP_CH+1] == $past(wr_data[7:0]);
  endproperty
  a_limit_write: assert property (p_limit_write) else $error("limit byte not stored");

  property p_bresp;
    @(posedge sys_clk) disable iff (srst)
    do_write |=> s_axi_bvalid ##0 (s_axi_bresp == (($past(wr_mapped)) ? RESP_OKAY : RESP_SLVERR));
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response wrong");

  property p_irq_event;
    @(posedge sys_clk) disable iff (srst)
    $rose(alarm[0]) && irq_mask_ff[0] && !(wr_byte && wr_idx == IDX_IRQ_MASK) |=> irq;
  endproperty
  a_irq_event: assert property (p_irq_event) else $error("interrupt missed rising alarm");

  property p_temp_hyst_field;
    @(posedge sys_clk) disable iff (srst)
    wr_byte && wr_idx == IDX_TEMP_HYST |=> g_ch[TEMP_CH].chan.hyst == {2'b00, $past(wr_data[4:0])};
  endproperty
  a_temp_hyst_field: assert property (p_temp_hyst_field) else $error("temp hysteresis too wide");
endmodule : oora_top

//--- hdl/oora_win_cmp.sv
// Purpose: window comparator with hysteresis for one channel
// Assumes: sample_valid is a one-cycle strobe per conversion
// Notes: arithmetic is 14-bit signed so both formats share one datapath
`timescale 1ns/1ps
module oora_win_cmp #(
  parameter bit SIGNED_CMP = 1'b0,  // temperature channel uses two's complement
  parameter int HYST_SHIFT = 0      // scales hysteresis steps to sample lsbs
) (
  input wire logic sys_clk,         // system clock
  input wire logic srst,            // synchronous reset, high
  oora_chan_if.cmp ch               // limits, sample and alarm
);
  import oora_pkg::*;

  logic signed [13:0] s_x;
  logic signed [13:0] up_x;
  logic signed [13:0] lo_x;
  logic signed [13:0] hy_x;
  logic               out_win;
  logic               in_margin;
  logic               alarm_ff;

  // widen by format; full 12 bits take part in every compare
  always_comb begin
    s_x  = SIGNED_CMP ? {{2{ch.sample[11]}}, ch.sample} : {2'b00, ch.sample};
    up_x = SIGNED_CMP ? {{2{ch.upper[11]}}, ch.upper} : {2'b00, ch.upper};
    lo_x = SIGNED_CMP ? {{2{ch.lower[11]}}, ch.lower} : {2'b00, ch.lower};
    hy_x = 14'({7'h00, ch.hyst} << HYST_SHIFT);
  end

  // an inverted window (upper below lower) leaves no sample inside it
  assign out_win   = (s_x > up_x) || (s_x < lo_x);
  assign in_margin = (s_x <= up_x - hy_x) && (s_x >= lo_x + hy_x);

  // alarm sets on leaving the window, clears only well inside it
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      alarm_ff <= 1'b0;
    end else if (ch.sample_valid) begin
      alarm_ff <= alarm_ff ? !in_margin : out_win;
    end
  end
  assign ch.alarm = alarm_ff;

  property p_out_sets;
    @(posedge sys_clk) disable iff (srst)
    ch.sample_valid && out_win |=> ch.alarm;
  endproperty
  a_out_sets: assert property (p_out_sets) else $error("alarm missed outside window");

  property p_hyst_hold;
    @(posedge sys_clk) disable iff (srst)
    ch.alarm && ch.sample_valid && !in_margin |=> ch.alarm;
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("alarm cleared inside margin");

  property p_clear_inside;
    @(posedge sys_clk) disable iff (srst)
    ch.sample_valid && in_margin && !out_win |=> !ch.alarm;
  endproperty
  a_clear_inside: assert property (p_clear_inside) else $error("alarm stuck inside margin");
endmodule : oora_win_cmp

//--- shared/oora_chan_if.sv
// Purpose: per-channel link between the register bank and a window comparator
// Assumes: one instance per monitored channel
// Notes: limits are raw register contents, the comparator picks the number format
`timescale 1ns/1ps
interface oora_chan_if;
  import oora_pkg::*;
  logic [DATA_W-1:0] upper;         // assembled upper limit
  logic [DATA_W-1:0] lower;         // assembled lower limit
  logic [HYST_W-1:0] hyst;          // hysteresis field
  logic [DATA_W-1:0] sample;        // newest conversion
  logic              sample_valid;  // conversion strobe
  logic              alarm;         // channel alarm flag
  modport ctl (output upper, lower, hyst, sample, sample_valid, input alarm);
  modport cmp (input upper, lower, hyst, sample, sample_valid, output alarm);
endinterface : oora_chan_if

//--- shared/oora_pkg.sv
// Purpose: constants for the out-of-range alarm threshold bank
// Assumes: register index = byte address / 4, 8-bit registers in bits 7:0
// Notes: channels 0..4 are unipolar inputs, channel 5 is the temperature sensor
package oora_pkg;
  localparam int          NUM_CH          = 6;      // five inputs plus temperature
  localparam int          TEMP_CH         = 5;
  localparam int          THR_BYTES       = 24;     // four limit bytes per channel
  localparam int          DATA_W          = 12;
  localparam int          HYST_W          = 7;
  localparam int          TEMP_HYST_W     = 5;
  localparam int          TEMP_HYST_SHIFT = 2;      // sample lsbs per degree = 4
  localparam int          ADDR_W          = 12;
  // register indices (byte address is four times the index)
  localparam logic [7:0]  IDX_THR_BASE    = 8'h80;  // input limits 0x80..0x93
  localparam logic [7:0]  IDX_TEMP_UP_LO  = 8'h94;
  localparam logic [7:0]  IDX_TEMP_UP_HI  = 8'h95;
  localparam logic [7:0]  IDX_TEMP_LO_LO  = 8'h96;
  localparam logic [7:0]  IDX_TEMP_LO_HI  = 8'h97;
  localparam logic [7:0]  IDX_HYST_BASE   = 8'ha0;  // input hysteresis 0xa0..0xa4
  localparam logic [7:0]  IDX_TEMP_HYST   = 8'ha5;
  localparam logic [7:0]  IDX_STATUS      = 8'hc0;
  localparam logic [7:0]  IDX_IRQ_STATUS  = 8'hc1;
  localparam logic [7:0]  IDX_IRQ_MASK    = 8'hc2;
  // byte position of each limit byte within a channel group
  localparam logic [1:0]  POS_UP_LO       = 2'h0;
  localparam logic [1:0]  POS_UP_HI       = 2'h1;
  localparam logic [1:0]  POS_LO_LO       = 2'h2;
  localparam logic [1:0]  POS_LO_HI       = 2'h3;
  // reset values
  localparam logic [7:0]  RST_UP_LO       = 8'hff;
  localparam logic [7:0]  RST_IN_UP_HI    = 8'h0f;
  localparam logic [7:0]  RST_TEMP_UP_HI  = 8'h07;
  localparam logic [7:0]  RST_LO_LO       = 8'h00;
  localparam logic [7:0]  RST_IN_LO_HI    = 8'h00;
  localparam logic [7:0]  RST_TEMP_LO_HI  = 8'h08;
  localparam logic [7:0]  RST_HYST        = 8'h08;
  // status layout
  localparam int          STAT_GLOBAL_BIT = 7;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : oora_pkg

//--- sim/oora_top_bench.sv
// Purpose: self-checking bench for the alarm threshold bank
// Assumes: single clock, registers one byte per aligned word
// Notes: expected values come from the register layout, never from the design
`timescale 1ns/1ps
module oora_top_bench;
  import oora_pkg::*;
  logic                          sys_clk       = 1'b0;
  logic                          srst          = 1'b1;
  logic [NUM_CH-1:0][DATA_W-1:0] sample_data   = '0;
  logic [NUM_CH-1:0]             sample_valid  = '0;
  logic [ADDR_W-1:0]             s_axi_awaddr  = '0;
  logic [ADDR_W-1:0]             s_axi_araddr  = '0;
  logic [31:0]                   s_axi_wdata   = '0;
  logic [3:0]                    s_axi_wstrb   = 4'hf;
  logic                          s_axi_awvalid = 1'b0;
  logic                          s_axi_wvalid  = 1'b0;
  logic                          s_axi_bready  = 1'b0;
  logic                          s_axi_arvalid = 1'b0;
  logic                          s_axi_rready  = 1'b0;
  logic                          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic                          s_axi_rvalid, global_alarm_flag, irq;
  logic [1:0]                    s_axi_bresp, s_axi_rresp;
  logic [31:0]                   s_axi_rdata;
  logic [NUM_CH-1:0]             channel_alarm_flag;
  int                            n_mismatch    = 0;
  int                            n_tests       = 0;
  int                            cycles        = 0;

  oora_top i_oora_top (.sys_clk(sys_clk), .srst(srst), .sample_data(sample_data),
    .sample_valid(sample_valid), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .channel_alarm_flag(channel_alarm_flag), .global_alarm_flag(global_alarm_flag), .irq(irq));

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // write one register; address and data are offered together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic [1:0] r;
    n = 0;
    r = 'x;
    @(posedge sys_clk);
    s_axi_awaddr  <= {2'b00, idx, 2'b00};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (n < 50) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        n = 99;
      end else n++;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask : wr

  // read one register and compare data and response
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
    int n;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    d = 'x;
    r = 'x;
    @(posedge sys_clk);
    s_axi_araddr  <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (n < 50) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        n = 99;
      end else n++;
    end
    s_axi_rready <= 1'b0;
    chk("rdata", {24'h0, exp}, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask : rd

  // one-cycle conversion strobe on one channel
  task automatic smp(input int ch, input logic [11:0] v);
    @(posedge sys_clk);
    sample_data[ch]  <= v;
    sample_valid[ch] <= 1'b1;
    @(posedge sys_clk);
    sample_valid <= '0;
  endtask : smp

  // one extra edge lets the sticky flag and interrupt status follow the alarm
  task automatic flags(input logic [5:0] a, input logic g, input logic q);
    @(posedge sys_clk);
    #1;
    chk("alarm", {26'h0, a}, {26'h0, channel_alarm_flag});
    chk("global", {31'h0, g}, {31'h0, global_alarm_flag});
    chk("irq", {31'h0, q}, {31'h0, irq});
  endtask : flags

  task automatic t_reset;
    rd(8'h80, 8'hff, RESP_OKAY);
    rd(8'h81, 8'h0f, RESP_OKAY);
    rd(8'h82, 8'h00, RESP_OKAY);
    rd(8'h83, 8'h00, RESP_OKAY);
    rd(8'h94, 8'hff, RESP_OKAY);
    rd(8'h95, 8'h07, RESP_OKAY);
    rd(8'h96, 8'h00, RESP_OKAY);
    rd(8'h97, 8'h08, RESP_OKAY);
    rd(8'ha0, 8'h08, RESP_OKAY);
    rd(8'ha5, 8'h08, RESP_OKAY);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_rw;
    wr(8'h93, 8'hf3, RESP_OKAY);
    rd(8'h93, 8'hf3, RESP_OKAY);
    // byte lane 0 off: answered OKAY, the stored byte must not move
    s_axi_wstrb <= 4'he;
    wr(8'h93, 8'h00, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(8'h93, 8'hf3, RESP_OKAY);
    wr(8'ha4, 8'hff, RESP_OKAY);
    rd(8'ha4, 8'hff, RESP_OKAY);
    wr(8'ha5, 8'he1, RESP_OKAY);
    rd(8'ha5, 8'he1, RESP_OKAY);
    wr(8'h98, 8'h5a, RESP_SLVERR);
    rd(8'h98, 8'h00, RESP_SLVERR);
    $display("test access and map done");
  endtask : t_rw

  // channel 0 window 0x010..0x100, default hysteresis 8 then 2
  task automatic t_input;
    wr(8'h80, 8'h00, RESP_OKAY);
    wr(8'h81, 8'h01, RESP_OKAY);
    wr(8'h82, 8'h10, RESP_OKAY);
    wr(8'hc2, 8'h01, RESP_OKAY);
    smp(0, 12'h100);
    flags(6'h00, 1'b0, 1'b0);
    smp(0, 12'h101);
    flags(6'h01, 1'b1, 1'b1);
    smp(0, 12'h0f9);
    flags(6'h01, 1'b1, 1'b1);
    smp(0, 12'h0f8);
    flags(6'h00, 1'b1, 1'b1);
    rd(8'hc0, 8'h80, RESP_OKAY);
    rd(8'hc0, 8'h00, RESP_OKAY);
    wr(8'ha0, 8'h02, RESP_OKAY);
    smp(0, 12'h00f);
    flags(6'h01, 1'b1, 1'b1);
    smp(0, 12'h011);
    flags(6'h01, 1'b1, 1'b1);
    smp(0, 12'h012);
    flags(6'h00, 1'b1, 1'b1);
    wr(8'hc1, 8'h01, RESP_OKAY);
    rd(8'hc0, 8'h80, RESP_OKAY);
    flags(6'h00, 1'b0, 1'b0);
    $display("test input window done");
  endtask : t_input

  // temperature upper limit 0x010, signed compare, 8 degrees = 32 lsb, irq masked
  task automatic t_temp;
    // spare bits set, field back to 8 degrees after the access test
    wr(8'ha5, 8'he8, RESP_OKAY);
    wr(8'h94, 8'h10, RESP_OKAY);
    wr(8'h95, 8'h00, RESP_OKAY);
    smp(5, 12'hff0);
    flags(6'h00, 1'b0, 1'b0);
    smp(5, 12'h011);
    flags(6'h20, 1'b1, 1'b0);
    rd(8'hc1, 8'h20, RESP_OKAY);
    smp(5, 12'hff1);
    flags(6'h20, 1'b1, 1'b0);
    smp(5, 12'hff0);
    flags(6'h00, 1'b1, 1'b0);
    $display("test temperature window done");
  endtask : t_temp

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // hang guard, far above the roughly 150 cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_rw();
    t_input();
    t_temp();
    test_done();
  end
endmodule : oora_top_bench
